//--- logic/tcq_channel.sv
// one capture/compare channel of the timer counter
`timescale 1ns/1ps
module tcq_channel #(
   parameter int W = 16
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire logic         i_wr_ctl,
   input  wire logic         i_wr_val,
   input  wire logic [W-1:0] i_wdata,
   input  wire logic         i_ctl_capture,
   input  wire logic         i_tick,
   input  wire logic [W-1:0] i_count,
   input  wire logic [W-1:0] i_next_count,
   input  wire logic         i_capture_in,
   input  wire logic         i_flag_clear,
   output logic              o_capture_mode,
   output logic [W-1:0]      o_value,
   output logic              o_flag
);

   // ****************************************
   // match and capture decode
   // ****************************************
   logic           eq_latched;
   logic           cap_prev;
   wire logic      cap_rise;
   wire logic      next_equal;
   wire logic      match_event;
   wire logic      event_any;

   // edge of the capture input, only in capture mode
   assign cap_rise    = o_capture_mode & i_capture_in & ~cap_prev;
   assign next_equal  = (i_next_count == o_value);
   // match raised on the step into the compare value
   // a match right after the last one is swallowed
   assign match_event = ~o_capture_mode & i_tick & next_equal & ~eq_latched;
   assign event_any   = match_event | cap_rise;

   // ****************************************
   // channel registers
   // ****************************************
   // mode bit and compare value
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_capture_mode <= 1'b0;
         o_value        <= '0;
      end else begin
         if (i_wr_ctl) o_capture_mode <= i_ctl_capture;
         if (cap_rise) o_value <= i_count;
         else if (i_wr_val) o_value <= i_wdata;
      end
   end

   // capture mode forgets the last match
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         eq_latched <= 1'b0;
         cap_prev   <= 1'b0;
      end else begin
         cap_prev <= i_capture_in;
         if (o_capture_mode) eq_latched <= 1'b0;
         else if (i_tick) eq_latched <= next_equal;
      end
   end

   // sticky flag, a new event beats the clear
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) o_flag <= 1'b0;
      else       o_flag <= event_any | (o_flag & ~i_flag_clear);
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   a_match_sets_flag: assert property (
      (~o_capture_mode && i_tick && next_equal && !eq_latched) |=> o_flag)
      else $error("compare match did not set flag");
   a_missed_match: assert property (
      (~o_capture_mode && i_tick && eq_latched && !o_flag && !cap_rise) |=> !o_flag)
      else $error("back to back match was not swallowed");
   a_capture_rearms: assert property (
      o_capture_mode |=> !eq_latched)
      else $error("capture mode left match latched");
   c_match_seen: cover property (match_event);
endmodule : tcq_channel

//--- logic/tcq_timer.sv
// package of constants and the timer counter top module
// Overview of operation
// - the counter steps on one selected source: inverted input, sub-main, auxiliary or external clock.
// - power-on reset or the clear bit sets the count to zero.
// - the first step after a clear comes on the first source edge whatever the divider says.
// - every later step comes at the rate set by the divider bits.
// - a channel in compare mode flags when the count reaches its compare value.
// - raising a compare value by one before the next step loses the match then due.
// - in up mode the wrap flag sets only on the roll from the period value to zero or on the restart edge.
// - stopped at the period value, cleared, then restarted in up mode, the next edge sets the wrap flag.
//
// The plain strobed port and the address map are this design's own decisions.
package tcq_pkg;
   localparam int         AW           = 8;
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_COUNT    = 8'h04;
   localparam logic [7:0] OFF_STATUS   = 8'h08;
   localparam logic [7:0] OFF_CH_BASE  = 8'h10;
   localparam logic [7:0] CH_STRIDE    = 8'h08;
   localparam logic [7:0] CH_VAL_OFF   = 8'h04;
   localparam int         CTRL_SRC_LSB = 0;
   localparam int         CTRL_DIV_LSB = 2;
   localparam int         CTRL_MODE_LSB = 4;
   localparam int         CTRL_CLR_BIT = 6;
   localparam int         STAT_WRAP_BIT = 0;
   localparam int         STAT_CH_LSB  = 1;
   localparam int         CCTL_CAP_BIT = 0;
   localparam logic [1:0] SRC_INV_IN   = 2'h0;
   localparam logic [1:0] SRC_SUB_MAIN = 2'h1;
   localparam logic [1:0] SRC_AUX      = 2'h2;
   localparam logic [1:0] SRC_EXT      = 2'h3;
   localparam logic [1:0] CTRL_SRC_RST = 2'h0;
   localparam logic [1:0] CTRL_DIV_RST = 2'h0;
   localparam int         PRESC_W      = 3;
   typedef enum logic [1:0] {
      TCQ_STOP = 2'b00,
      TCQ_UP   = 2'b01,
      TCQ_CONT = 2'b10,
      TCQ_HOLD = 2'b11
   } tcq_mode_type;
endpackage : tcq_pkg

`timescale 1ns/1ps
module tcq_timer #(
   parameter int W   = 16,
   parameter int NCH = 3
) (
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_rst,
   input  wire logic [tcq_pkg::AW-1:0] i_addr,
   input  wire logic [31:0]            i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   input  wire logic                   i_inverted_input_clock,
   input  wire logic                   i_sub_main_clock,
   input  wire logic                   i_aux_clock,
   input  wire logic                   i_external_timer_clock,
   input  wire logic [NCH-1:0]         i_capture_in,
   output logic [31:0]                 o_rdata,
   output logic [W-1:0]                o_timer_count_value,
   output logic                        o_counter_wrap_flag,
   output logic [NCH-1:0]              o_compare_flag
);

   // ****************************************
   // control state
   // ****************************************
   logic [1:0]                 src_sel;
   logic [1:0]                 input_divider_bits;
   tcq_pkg::tcq_mode_type      mode;
   logic                       src_prev;
   logic                       first_pending;
   logic                       stop_armed;
   logic                       stop_seen;
   logic                       src_switch;
   logic [tcq_pkg::PRESC_W-1:0] presc;
   logic [NCH-1:0]             cap_mode;
   logic [W-1:0]               ch_value [NCH];

   // ****************************************
   // register decode
   // ****************************************
   wire logic       wr_ctrl   = i_wr && (i_addr == tcq_pkg::OFF_CTRL);
   wire logic       wr_status = i_wr && (i_addr == tcq_pkg::OFF_STATUS);
   wire logic       clear_req = wr_ctrl && i_wdata[tcq_pkg::CTRL_CLR_BIT];
   wire logic [NCH-1:0] wr_cctl;
   wire logic [NCH-1:0] wr_cval;
   wire logic [NCH-1:0] ch_clear = wr_status ? i_wdata[tcq_pkg::STAT_CH_LSB +: NCH] : '0;
   wire logic       wrap_clear = wr_status && i_wdata[tcq_pkg::STAT_WRAP_BIT];
   wire logic       src_change = wr_ctrl && (i_wdata[tcq_pkg::CTRL_SRC_LSB +: 2] != src_sel);

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_dec
         localparam logic [7:0] CTL_A = 8'(tcq_pkg::OFF_CH_BASE + tcq_pkg::CH_STRIDE * g);
         assign wr_cctl[g] = i_wr && (i_addr == CTL_A);
         assign wr_cval[g] = i_wr && (i_addr == 8'(CTL_A + tcq_pkg::CH_VAL_OFF));
      end
   endgenerate

   // ****************************************
   // clock source and divider
   // ****************************************
   // one of four sources, rising edge only
   wire logic src_now = (src_sel == tcq_pkg::SRC_INV_IN)   ? i_inverted_input_clock :
                        (src_sel == tcq_pkg::SRC_SUB_MAIN) ? i_sub_main_clock :
                        (src_sel == tcq_pkg::SRC_AUX)      ? i_aux_clock : i_external_timer_clock;
   wire logic running = (mode == tcq_pkg::TCQ_UP) || (mode == tcq_pkg::TCQ_CONT);
   wire logic src_rise = src_now & ~src_prev;
   wire logic tick     = src_rise & running & ~clear_req & ~src_switch;
   wire logic [tcq_pkg::PRESC_W-1:0] div_last =
      tcq_pkg::PRESC_W'((4'h1 << input_divider_bits) - 4'h1);
   // first step ignores the divider; later ones honour it
   wire logic advance = tick & (first_pending | (presc == div_last));

   // ****************************************
   // next count and wrap
   // ****************************************
   wire logic       at_period = (o_timer_count_value == ch_value[0]);
   wire logic       at_max    = &o_timer_count_value;
   wire logic       is_up     = (mode == tcq_pkg::TCQ_UP);
   wire logic [W-1:0] next_count = (is_up && at_period) ? '0 : W'(o_timer_count_value + 1'b1);
   // roll from period to zero in up mode, or full roll when counting on
   wire logic wrap_roll = advance & ((is_up & at_period) | (~is_up & at_max));
   // stale period state sets the flag on the restart edge
   wire logic wrap_restart = tick & is_up & stop_armed;
   wire logic wrap_event   = wrap_roll | wrap_restart;
   wire logic [W-1:0] ch_next = advance ? next_count : o_timer_count_value;

   // control register
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         src_sel            <= tcq_pkg::CTRL_SRC_RST;
         input_divider_bits <= tcq_pkg::CTRL_DIV_RST;
         mode               <= tcq_pkg::TCQ_STOP;
      end else if (wr_ctrl) begin
         src_sel            <= i_wdata[tcq_pkg::CTRL_SRC_LSB +: 2];
         input_divider_bits <= i_wdata[tcq_pkg::CTRL_DIV_LSB +: 2];
         mode               <= tcq_pkg::tcq_mode_type'(i_wdata[tcq_pkg::CTRL_MODE_LSB +: 2]);
      end
   end

   // after a source change the old level is not taken as an edge
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) src_switch <= 1'b0;
      else       src_switch <= src_change;
   end

   // reset or clear bit zeroes the count and restarts the divider
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_timer_count_value <= '0;
         presc               <= '0;
         first_pending       <= 1'b1;
         src_prev            <= 1'b0;
      end else begin
         src_prev <= src_now;
         if (clear_req) begin
            o_timer_count_value <= '0;
            presc               <= '0;
            first_pending       <= 1'b1;
         end else if (tick) begin
            o_timer_count_value <= ch_next;
            presc               <= (advance) ? '0 : tcq_pkg::PRESC_W'(presc + 1'b1);
            first_pending       <= 1'b0;
         end
      end
   end

   // a stop at the period value followed by a clear arms the restart flag
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         stop_seen  <= 1'b0;
         stop_armed <= 1'b0;
      end else begin
         stop_seen <= (mode == tcq_pkg::TCQ_STOP) && at_period && !clear_req;
         if (tick) stop_armed <= 1'b0;
         else if (clear_req && stop_seen) stop_armed <= 1'b1;
      end
   end

   // sticky wrap flag, event beats the clear
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) o_counter_wrap_flag <= 1'b0;
      else       o_counter_wrap_flag <= wrap_event | (o_counter_wrap_flag & ~wrap_clear);
   end

   // ****************************************
   // channels
   // ****************************************
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         tcq_channel #(.W(W)) u_ch (
            .i_sys_clk      (i_sys_clk),
            .i_rst          (i_rst),
            .i_wr_ctl       (wr_cctl[g]),
            .i_wr_val       (wr_cval[g]),
            .i_wdata        (i_wdata[W-1:0]),
            .i_ctl_capture  (i_wdata[tcq_pkg::CCTL_CAP_BIT]),
            .i_tick         (advance),
            .i_count        (o_timer_count_value),
            .i_next_count   (next_count),
            .i_capture_in   (i_capture_in[g]),
            .i_flag_clear   (ch_clear[g]),
            .o_capture_mode (cap_mode[g]),
            .o_value        (ch_value[g]),
            .o_flag         (o_compare_flag[g])
         );
      end
   endgenerate

   // ****************************************
   // read path
   // ****************************************
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (i_addr)
         tcq_pkg::OFF_CTRL:   rd_mux = 32'({mode, input_divider_bits, src_sel});
         tcq_pkg::OFF_COUNT:  rd_mux = 32'(o_timer_count_value);
         tcq_pkg::OFF_STATUS: rd_mux = 32'({o_compare_flag, o_counter_wrap_flag});
         default: begin
            for (int k = 0; k < NCH; k++) begin
               if (i_addr == 8'(tcq_pkg::OFF_CH_BASE + tcq_pkg::CH_STRIDE * k)) rd_mux = 32'(cap_mode[k]);
               if (i_addr == 8'(tcq_pkg::OFF_CH_BASE + tcq_pkg::CH_STRIDE * k + tcq_pkg::CH_VAL_OFF))
                  rd_mux = 32'(ch_value[k]);
            end
         end
      endcase
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst)     o_rdata <= 32'h0000_0000;
      else if (i_rd) o_rdata <= rd_mux;
      else           o_rdata <= 32'h0000_0000;
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   a_source_edge: assert property (
      tick |-> src_now && !src_prev && running)
      else $error("count step without a source edge");
   a_clear_zeroes: assert property (
      clear_req |=> (o_timer_count_value == '0) && first_pending)
      else $error("clear did not zero the count");
   a_first_step: assert property (
      (first_pending && tick) |=> o_timer_count_value == $past(next_count))
      else $error("first step after clear was held by divider");
   a_divider_hold: assert property (
      (tick && !first_pending && presc != div_last) |=> $stable(o_timer_count_value))
      else $error("count stepped before divider expired");
   a_wrap_cause: assert property (
      (!o_counter_wrap_flag ##1 o_counter_wrap_flag) |-> $past(wrap_roll) || $past(wrap_restart))
      else $error("wrap flag set without a roll");
   a_restart_wrap: assert property (
      (tick && is_up && stop_armed) |=> o_counter_wrap_flag)
      else $error("restart edge did not set wrap flag");
   a_flag_sticky: assert property (
      (o_counter_wrap_flag && !wrap_clear) |=> o_counter_wrap_flag [*1])
      else $error("wrap flag dropped without a clear");
   a_read_timing: assert property (
      (!i_rd) |=> o_rdata == 32'h0000_0000)
      else $error("read data outside read slot");

   // ****************************************
   // stop, source, divider, roll, wrap and read checks
   // ****************************************
   a_stop_holds: assert property (
      (!running && !clear_req) |=> $stable(o_timer_count_value))
      else $error("count moved while stopped");
   a_switch_no_edge: assert property (
      src_switch |-> !tick)
      else $error("source change taken as an edge");
   a_divider_rate: assert property (
      (advance && !first_pending) |-> presc == div_last)
      else $error("later step off the divider rate");
   a_up_period_roll: assert property (
      (advance && is_up && at_period) |=> o_timer_count_value == '0)
      else $error("up mode did not roll at the period");
   a_cont_no_wrap: assert property (
      (advance && !is_up && !at_max && !o_counter_wrap_flag) |=> !o_counter_wrap_flag)
      else $error("wrap flag set before the full roll");
   a_armed_needs_clear: assert property (
      (!stop_armed ##1 stop_armed) |-> $past(clear_req))
      else $error("restart quirk armed without a clear");
   a_wrap_set_wins: assert property (
      wrap_event |=> o_counter_wrap_flag)
      else $error("wrap event lost");
   a_wrap_clear: assert property (
      (wrap_clear && !wrap_event) |=> !o_counter_wrap_flag)
      else $error("wrap flag survived its clear");
   a_read_count: assert property (
      (i_rd && (i_addr == tcq_pkg::OFF_COUNT)) |=> o_rdata == 32'($past(o_timer_count_value)))
      else $error("count read returned a wrong value");

   c_up_roll: cover property (advance && is_up && at_period);
   c_restart_quirk: cover property (wrap_restart);
   c_clear_then_step: cover property (clear_req ##[1:20] advance);
   c_cont_step: cover property (advance && !is_up);
endmodule : tcq_timer

//--- tb/tcq_timer_test.sv
// self-checking testbench for the timer counter
`timescale 1ns/1ps
module tcq_timer_test;
   // ****
   // signals and design instance
   // ****
   logic        sys_clk;
   logic        rst;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [3:0]  src;
   logic [2:0]  cap;
   logic [31:0] rdata;
   logic [15:0] count;
   logic        wrap;
   logic [2:0]  cflag;
   logic [31:0] d;
   int          n_fail;
   int          tests_run;
   localparam logic [31:0] WRAP_M = 32'h0000_0001 << tcq_pkg::STAT_WRAP_BIT;
   localparam logic [31:0] CH1_M  = 32'h0000_0001 << (tcq_pkg::STAT_CH_LSB + 1);

   tcq_timer i_tcq_timer (
      .i_sys_clk(sys_clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .i_inverted_input_clock(src[0]), .i_sub_main_clock(src[1]),
      .i_aux_clock(src[2]), .i_external_timer_clock(src[3]), .i_capture_in(cap),
      .o_rdata(rdata), .o_timer_count_value(count), .o_counter_wrap_flag(wrap),
      .o_compare_flag(cflag)
   );

   // ****
   // helpers
   // ****
   // compare and count mismatches
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      @(posedge sys_clk);
   endtask : wr_reg

   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 v = rdata;
      @(posedge sys_clk);
   endtask : rd_reg

   task automatic ctrl(input logic [1:0] s, input logic [1:0] dv, input logic [1:0] m, input logic c);
      wr_reg(tcq_pkg::OFF_CTRL, {25'h0, c, m, dv, s});
   endtask : ctrl

   function automatic logic [7:0] chv(input int n);
      return 8'(tcq_pkg::OFF_CH_BASE + n * tcq_pkg::CH_STRIDE + tcq_pkg::CH_VAL_OFF);
   endfunction : chv

   // rising edges on one count source, slow against the system clock
   task automatic pulse(input int s, input int n);
      repeat (n) begin
         src[s] <= 1'b1;
         repeat (3) @(posedge sys_clk);
         src[s] <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
   endtask : pulse

   task automatic cnt(input logic [15:0] e);
      chk({16'h0000, count}, {16'h0000, e});
   endtask : cnt

   task automatic st_clr;
      wr_reg(tcq_pkg::OFF_STATUS, 32'h0000_000f);
   endtask : st_clr

   task automatic finish_test;
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test

   // ****
   // clock, watchdog and sequence
   // ****
   // 50 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      finish_test;
   end

   // main test sequence
   initial begin
      rst = 1'b1;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
      src = 4'h0;
      cap = 3'h0;
      n_fail = 0;
      tests_run = 0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      cnt(16'h0000);
      rd_reg(tcq_pkg::OFF_CTRL, d);
      chk(d, 32'h0000_0000);
      rd_reg(tcq_pkg::OFF_STATUS, d);
      chk(d, 32'h0000_0000);
      rd_reg(8'hfc, d);
      chk(d, 32'h0000_0000);
      wr_reg(chv(0), 32'h0000_0064);
      for (int s = 0; s < 4; s++) begin
         ctrl(2'(s), 2'h0, tcq_pkg::TCQ_UP, 1'b1);
         pulse((s + 1) % 4, 1);
         cnt(16'h0000);
         pulse(s, 1);
         cnt(16'h0001);
      end
      chk({31'h0, wrap}, 32'h0000_0000);
      rd_reg(tcq_pkg::OFF_CTRL, d);
      chk(d, 32'h0000_0013);
      // first step ignores the divider, later ones obey it
      for (int k = 0; k < 2; k++) begin
         ctrl(tcq_pkg::SRC_SUB_MAIN, 2'h2, tcq_pkg::TCQ_UP, 1'b1);
         cnt(16'h0000);
         pulse(1, 1);
         cnt(16'h0001);
      end
      pulse(1, 3);
      cnt(16'h0001);
      pulse(1, 1);
      rd_reg(tcq_pkg::OFF_COUNT, d);
      chk(d, 32'h0000_0002);
      ctrl(tcq_pkg::SRC_SUB_MAIN, 2'h0, tcq_pkg::TCQ_UP, 1'b1);
      wr_reg(chv(1), 32'h0000_0002);
      st_clr;
      pulse(1, 1);
      chk({31'h0, cflag[1]}, 32'h0000_0000);
      pulse(1, 1);
      chk({31'h0, cflag[1]}, 32'h0000_0001);
      rd_reg(tcq_pkg::OFF_STATUS, d);
      chk(d & CH1_M, CH1_M);
      st_clr;
      chk({31'h0, cflag[1]}, 32'h0000_0000);
      // raise by one loses the next match
      wr_reg(chv(1), 32'h0000_0003);
      pulse(1, 1);
      cnt(16'h0003);
      chk({31'h0, cflag[1]}, 32'h0000_0000);
      // capture mode around the raise keeps it
      wr_reg(tcq_pkg::OFF_CH_BASE + tcq_pkg::CH_STRIDE, 32'h0000_0001);
      wr_reg(chv(1), 32'h0000_0004);
      wr_reg(tcq_pkg::OFF_CH_BASE + tcq_pkg::CH_STRIDE, 32'h0000_0000);
      pulse(1, 1);
      chk({31'h0, cflag[1]}, 32'h0000_0001);
      // wrap only on the roll from the period to zero
      wr_reg(chv(0), 32'h0000_0002);
      ctrl(tcq_pkg::SRC_SUB_MAIN, 2'h0, tcq_pkg::TCQ_UP, 1'b1);
      st_clr;
      pulse(1, 2);
      chk({31'h0, wrap}, 32'h0000_0000);
      chk({31'h0, cflag[0]}, 32'h0000_0001);
      pulse(1, 1);
      cnt(16'h0000);
      rd_reg(tcq_pkg::OFF_STATUS, d);
      chk(d & WRAP_M, WRAP_M);
      // stop at period, clear, restart sets wrap on first edge
      st_clr;
      pulse(1, 2);
      ctrl(tcq_pkg::SRC_SUB_MAIN, 2'h0, tcq_pkg::TCQ_STOP, 1'b0);
      repeat (2) @(posedge sys_clk);
      ctrl(tcq_pkg::SRC_SUB_MAIN, 2'h0, tcq_pkg::TCQ_STOP, 1'b1);
      cnt(16'h0000);
      ctrl(tcq_pkg::SRC_SUB_MAIN, 2'h0, tcq_pkg::TCQ_UP, 1'b0);
      st_clr;
      chk({31'h0, wrap}, 32'h0000_0000);
      pulse(1, 1);
      cnt(16'h0001);
      chk({31'h0, wrap}, 32'h0000_0001);
      // capture mode takes the count on a capture edge
      wr_reg(8'(tcq_pkg::OFF_CH_BASE + 2 * tcq_pkg::CH_STRIDE), 32'h0000_0001);
      cap[2] <= 1'b1;
      @(posedge sys_clk);
      cap[2] <= 1'b0;
      @(posedge sys_clk);
      chk({31'h0, cflag[2]}, 32'h0000_0001);
      rd_reg(chv(2), d);
      chk(d, 32'h0000_0001);
      // continuous mode runs past the period without a wrap
      ctrl(tcq_pkg::SRC_SUB_MAIN, 2'h0, tcq_pkg::TCQ_CONT, 1'b1);
      st_clr;
      pulse(1, 3);
      cnt(16'h0003);
      chk({31'h0, wrap}, 32'h0000_0000);
      chk({31'h0, cflag[0]}, 32'h0000_0001);
      finish_test;
   end
endmodule : tcq_timer_test
